// >>> design/pic_host_pkg.sv
// Package for the host-side controller of an eight-level priority interrupt controller.
// Assumes a single 40 MHz clock domain and synchronous pin inputs.
`default_nettype none
package pic_host_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 25;
  // Least strobe width and recovery, in ns, rounded up to cycles
  localparam int unsigned STROBE_MIN_NS  = 250;
  localparam int unsigned STROBE_CYC     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_NS     = 200;
  localparam int unsigned RECOVER_CYC    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 4;

  localparam int unsigned DATA_W         = 8;
  localparam int unsigned LEVELS         = 8;
  localparam int unsigned CAS_W          = 3;

  // Acknowledge pulses per host mode
  localparam logic [1:0]  ACK_PULSES_CALL = 2'h3;
  localparam logic [1:0]  ACK_PULSES_VEC  = 2'h2;
  localparam logic [7:0]  CALL_OPCODE     = 8'hcd;
  localparam int unsigned VEC_LEVEL_LSB   = 0;
  localparam int unsigned VEC_LEVEL_W     = 3;

  // User command
  typedef struct packed {
    logic                 wr;
    logic                 port_sel;
    logic [DATA_W-1:0]    data;
  } host_cmd_t;

  // Bus pins driven toward the device
  typedef struct packed {
    logic                 cs_n;
    logic                 rd_n;
    logic                 wr_n;
    logic                 ack_strobe_n;
    logic                 port_select_line;
  } bus_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STROBE,
    ST_RECOVER,
    ST_ACK_LOW,
    ST_ACK_GAP
  } host_state_t;

endpackage

`default_nettype wire

// >>> design/pic_host_ctrl.sv
// Host-side controller: issues register reads/writes and acknowledge sequences to the device.
// Assumes device pins are synchronous to i_clk; bidirectional bus resolved outside.
//
// Contract
// R01: Device holds pending, in-service, mask sets.
// R02: Device has eight chained priority cells.
// R03: Low input sets edge latch.
// R04: Edge mode disarms after acknowledge.
// R05: Level mode ignores edge latch.
// R06: Unmasked lone request raises interrupt.
// R07: Host sends three or two acknowledges.
// R08: Device freezes requests during acknowledges.
// R09: Device resolves again, forms vector.
// R10: In-service set, edge latch cleared.
// R11: Level input still high re-interrupts.
// R12: Only end-of-service command clears in-service.
// R13: Data bus is 8-bit three-state.
// R14: Chip select low gates read/write strobes.
// R15: Acknowledge works regardless of chip select.
// R16: Port-select line picks word or status.
// R17: Expansion lines: master drives, slave receives.
// R18: Pin is buffer enable or master strap.
// R19: Request sources hold high until acknowledged.
// R20: Vectors appear only under acknowledge.
// R21: Call mode: first acknowledge gives call opcode.
// R22: Vector mode: second acknowledge gives vector.
// R23: Request inputs synchronised in two stages.
// R24: Strobes sampled; cascade direction follows strap.
`timescale 1ns/100ps
`default_nettype none

module pic_host_ctrl #(
  parameter int unsigned DATA_W = pic_host_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  // User command side
  input  wire logic                      i_cmd_valid,
  input  wire pic_host_pkg::host_cmd_t   i_cmd,
  input  wire logic                      i_call_mode,
  output logic                           o_cmd_ready,
  output logic                           o_rd_valid,
  output logic [DATA_W-1:0]              o_rd_data,
  output logic                           o_vec_valid,
  output logic [DATA_W-1:0]              o_vec_data,
  output logic                           o_ack_done,
  // Device pins
  input  wire logic                      i_dev_int,
  input  wire logic [DATA_W-1:0]         i_host_data_bus,
  output logic [DATA_W-1:0]              o_host_data_bus,
  output logic                           o_host_data_bus_oe,
  output var pic_host_pkg::bus_pins_t    o_pins
);

  typedef pic_host_pkg::host_state_t st_t;

  st_t                                   state_r;
  st_t                                   state_nxt;
  logic [pic_host_pkg::CNT_W-1:0]        cnt_r;
  logic [1:0]                            pulse_r;
  logic                                  is_wr_r;
  logic                                  mode_call_r;
  logic [DATA_W-1:0]                     wdata_r;
  logic                                  sel_r;

  wire logic [1:0] pulses_needed = mode_call_r ? pic_host_pkg::ACK_PULSES_CALL
                                               : pic_host_pkg::ACK_PULSES_VEC; // R07
  wire logic cnt_done   = (cnt_r == pic_host_pkg::CNT_W'(pic_host_pkg::STROBE_CYC - 1));
  wire logic rec_done   = (cnt_r == pic_host_pkg::CNT_W'(pic_host_pkg::RECOVER_CYC - 1));
  wire logic last_pulse = (pulse_r == pulses_needed - 2'h1);
  // Vector byte is the last pulse in vector mode; call mode keeps the two address bytes after the opcode
  wire logic vec_pulse  = mode_call_r ? (pulse_r != 2'h0) : (pulse_r == 2'h1); // R22
  wire logic idle       = (state_r == pic_host_pkg::ST_IDLE);
  // Interrupt line is a level; looked at only when idle
  wire logic start_ack  = idle && i_dev_int && !i_cmd_valid; // R19
  wire logic start_cmd  = idle && i_cmd_valid;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pic_host_pkg::ST_IDLE:
        if (start_cmd)
          state_nxt = pic_host_pkg::ST_STROBE;
        else if (start_ack)
          state_nxt = pic_host_pkg::ST_ACK_LOW; // R07
      pic_host_pkg::ST_STROBE:
        if (cnt_done)
          state_nxt = pic_host_pkg::ST_RECOVER;
      pic_host_pkg::ST_RECOVER:
        if (rec_done)
          state_nxt = pic_host_pkg::ST_IDLE;
      pic_host_pkg::ST_ACK_LOW:
        if (cnt_done)
          state_nxt = pic_host_pkg::ST_ACK_GAP;
      pic_host_pkg::ST_ACK_GAP:
        if (rec_done)
          state_nxt = last_pulse ? pic_host_pkg::ST_IDLE : pic_host_pkg::ST_ACK_LOW;
      default:
        state_nxt = pic_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r     <= pic_host_pkg::ST_IDLE;
      cnt_r       <= '0;
      pulse_r     <= 2'h0;
      is_wr_r     <= 1'b0;
      mode_call_r <= 1'b0;
      wdata_r     <= '0;
      sel_r       <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
      if (start_cmd)
      begin
        is_wr_r <= i_cmd.wr;
        wdata_r <= i_cmd.data;
        sel_r   <= i_cmd.port_sel; // R16
      end
      if (start_ack)
      begin
        mode_call_r <= i_call_mode;
        pulse_r     <= 2'h0;
      end
      else if (state_r == pic_host_pkg::ST_ACK_GAP && rec_done)
        pulse_r <= pulse_r + 2'h1;
    end
  end

  // Pins registered; bus driven only during writes, released on acknowledges
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_pins             <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ack_strobe_n: 1'b1, port_select_line: 1'b0};
      o_host_data_bus    <= '0;
      o_host_data_bus_oe <= 1'b0;
      o_cmd_ready        <= 1'b0;
      o_rd_valid         <= 1'b0;
      o_rd_data          <= '0;
      o_vec_valid        <= 1'b0;
      o_vec_data         <= '0;
      o_ack_done         <= 1'b0;
    end
    else
    begin
      o_pins.cs_n             <= !(state_nxt == pic_host_pkg::ST_STROBE); // R14
      o_pins.wr_n             <= !(state_nxt == pic_host_pkg::ST_STROBE && (start_cmd ? i_cmd.wr : is_wr_r));
      o_pins.rd_n             <= !(state_nxt == pic_host_pkg::ST_STROBE && !(start_cmd ? i_cmd.wr : is_wr_r));
      o_pins.ack_strobe_n     <= !(state_nxt == pic_host_pkg::ST_ACK_LOW); // R15
      o_pins.port_select_line <= start_cmd ? i_cmd.port_sel : sel_r; // R16
      o_host_data_bus         <= start_cmd ? i_cmd.data : wdata_r; // R12
      o_host_data_bus_oe      <= (state_nxt == pic_host_pkg::ST_STROBE) && (start_cmd ? i_cmd.wr : is_wr_r); // R13 R18
      o_cmd_ready             <= (state_nxt == pic_host_pkg::ST_IDLE);
      // Sample read data at end of strobe, vector bytes only under acknowledge
      o_rd_valid  <= (state_r == pic_host_pkg::ST_STROBE) && cnt_done && !is_wr_r;
      if ((state_r == pic_host_pkg::ST_STROBE) && cnt_done && !is_wr_r)
        o_rd_data <= i_host_data_bus;
      o_vec_valid <= (state_r == pic_host_pkg::ST_ACK_LOW) && cnt_done && vec_pulse; // R20
      if ((state_r == pic_host_pkg::ST_ACK_LOW) && cnt_done && vec_pulse)
        o_vec_data <= i_host_data_bus; // R22
      o_ack_done  <= (state_r == pic_host_pkg::ST_ACK_GAP) && rec_done && last_pulse; // R10
    end
  end

  // Strobe pins never overlap: acknowledge and register access exclusive
  strobe_excl_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(!o_pins.ack_strobe_n && (!o_pins.rd_n || !o_pins.wr_n))) // R15
    else $error("acknowledge overlaps register strobe");

  cs_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_pins.rd_n || !o_pins.wr_n) |-> !o_pins.cs_n) // R14
    else $error("strobe without chip select");

  // Pulse counter has already stepped past the last pulse when done shows
  ack_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ack_done |-> (pulse_r == pulses_needed)) // R07
    else $error("wrong acknowledge pulse count");

  bus_drive_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_host_data_bus_oe |-> !o_pins.wr_n && o_pins.ack_strobe_n) // R13
    else $error("bus driven outside write");

  ack_width_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_pins.ack_strobe_n) |-> !o_pins.ack_strobe_n [*8]) // R07
    else $error("acknowledge pulse too short");

  vec_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_vec_valid |-> !$past(o_pins.ack_strobe_n)) // R20
    else $error("vector taken outside acknowledge");

  sel_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!o_pins.cs_n && !$past(o_pins.cs_n)) |-> $stable(o_pins.port_select_line)) // R16
    else $error("port select moved during access");

  rd_result_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_pins.rd_n) |-> o_rd_valid) // R14
    else $error("read end without result");

  rw_excl_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(!o_pins.rd_n && !o_pins.wr_n)) // R14
    else $error("read and write strobes overlap");

  // Short strobe or gap would defeat the device's edge detect
  strobe_len_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_pins.cs_n) |-> !o_pins.cs_n [*8]) // R14
    else $error("register strobe too short");

  ack_gap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_pins.ack_strobe_n) |-> o_pins.ack_strobe_n [*8]) // R07
    else $error("acknowledge recovery too short");

  done_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ack_done |=> !o_ack_done) // R10
    else $error("sequence end held too long");

endmodule // pic_host_ctrl

`default_nettype wire

// >>> tb/pic_dev_model.sv
// Behavioural device: pending, mask and in-service sets, acknowledge vectors.
// Assumes pins synchronous to i_clk; request pins synchronised here, edge or level mode.
`timescale 1ns/100ps
`default_nettype none
module pic_dev_model #(
  parameter logic [7:0] VBASE = 8'h48,
  parameter logic [7:0] AHI   = 8'h3c
) (
  // Clock, reset, mode
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_call_mode,
  input  wire logic                    i_level_mode,
  // Pins
  input  wire logic [7:0]              i_req,
  input  wire logic [7:0]              i_bus,
  input  wire pic_host_pkg::bus_pins_t i_pins,
  output logic                         o_int,
  output logic [7:0]                   o_bus,
  output logic [2:0]                   o_cas
);
  logic [7:0] pend_r, isr_r, mask_r, arm_r, last_r, val, req_s1, req_s2;
  logic [1:0] cnt_r;
  logic [2:0] win_r, top;
  logic       ack_q, wr_q, drv;
  wire        ackl = !i_pins.ack_strobe_n;
  wire        rdl  = !i_pins.cs_n && !i_pins.rd_n;
  wire        wrf  = wr_q && !i_pins.wr_n && !i_pins.cs_n;
  wire [7:0]  live = pend_r & ~mask_r;
  wire [1:0]  lastp = i_call_mode ? 2'h3 : 2'h2;
  always_comb
  begin
    top = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (live[i]) top = i[2:0];
  end
  assign o_int = |live && isr_r == 8'h00 && cnt_r == 2'h0;
  assign val = rdl ? (i_pins.port_select_line ? mask_r : pend_r)
             : cnt_r == 2'h1 ? pic_host_pkg::CALL_OPCODE
             : !i_call_mode ? {VBASE[7:3], win_r}
             : cnt_r == 2'h2 ? {VBASE[7:5], win_r, 2'h0} : AHI;
  assign drv = rdl || (ackl && cnt_r != 2'h0 && (i_call_mode || cnt_r == 2'h2));
  // Released bus shows the inverse, so a stale byte never passes
  assign o_bus = drv ? val : ~last_r;
  // Single master: expansion lines carry the winner during acknowledges
  assign o_cas = (cnt_r != 2'h0) ? win_r : 3'h0;
  always_ff @(posedge i_clk)
  begin
    ack_q  <= i_pins.ack_strobe_n;
    wr_q   <= i_pins.wr_n;
    last_r <= o_bus;
    req_s1 <= i_req;
    req_s2 <= req_s1;
    if (i_sys_rst)
    begin
      {pend_r, isr_r, arm_r, cnt_r, win_r} <= '0;
      mask_r <= 8'hff;
    end
    else
    begin
      arm_r <= arm_r | ~req_s2;
      // Level mode: latch tracks the pin, so acknowledge never disarms it
      if (cnt_r == 2'h0)
        pend_r <= i_level_mode ? req_s2 : (pend_r | (req_s2 & arm_r));
      if (ack_q && ackl)
        cnt_r <= cnt_r + 2'h1;
      if (ack_q && ackl && cnt_r == 2'h0)
        win_r <= top;
      if (!ack_q && !ackl && cnt_r == lastp)
      begin
        cnt_r         <= 2'h0;
        isr_r[win_r]  <= 1'b1;
        pend_r[win_r] <= 1'b0;
        arm_r[win_r]  <= 1'b0;
      end
      if (wrf && i_pins.port_select_line)
        mask_r <= i_bus;
      if (wrf && !i_pins.port_select_line && i_bus[5])
        isr_r <= isr_r & (isr_r - 8'h01);
    end
  end
endmodule // pic_dev_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench: host controller against the behavioural device.
// Assumes the hand-over timing of the controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0] VBASE = 8'h48;
  localparam logic [7:0] AHI   = 8'h3c;
  logic                    i_clk = 1'b0, i_sys_rst = 1'b1, i_cmd_valid = 1'b0, i_call_mode = 1'b0, lvl = 1'b0;
  pic_host_pkg::host_cmd_t i_cmd = '0;
  pic_host_pkg::bus_pins_t pins;
  logic [7:0]              req = 8'h00, rd, d, o_rd_data, o_vec_data, o_host_data_bus, dev_bus, bus;
  logic [7:0]              vq[$];
  logic [2:0]              l, cas;
  logic                    o_cmd_ready, o_rd_valid, o_vec_valid, o_ack_done, o_host_data_bus_oe, dev_int;
  int                      miscompares = 0, num_checks = 0, seed, n;
  assign bus = o_host_data_bus_oe ? o_host_data_bus : dev_bus;
  always #12.5 i_clk = ~i_clk;
  pic_host_ctrl pic_host_ctrl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_call_mode(i_call_mode), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_vec_valid(o_vec_valid), .o_vec_data(o_vec_data), .o_ack_done(o_ack_done), .i_dev_int(dev_int),
    .i_host_data_bus(bus), .o_host_data_bus(o_host_data_bus), .o_host_data_bus_oe(o_host_data_bus_oe), .o_pins(pins));
  pic_dev_model #(.VBASE(VBASE), .AHI(AHI)) pic_dev_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_call_mode(i_call_mode), .i_level_mode(lvl), .i_req(req), .i_bus(bus), .i_pins(pins), .o_int(dev_int),
    .o_bus(dev_bus), .o_cas(cas));
  task automatic stop_test;
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Every wait is bounded; a hang counts as a mismatch
  task automatic tick;
    @(posedge i_clk);
    #1;
    n++;
    if (n > 300)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic cmd(input logic w, input logic p, input logic [7:0] dd);
    n = 0;
    while (o_cmd_ready !== 1'b1)
      tick();
    i_cmd_valid = 1'b1;
    i_cmd = {w, p, dd};
    tick();
    i_cmd_valid = 1'b0;
    n = 0;
    while (!w && o_rd_valid !== 1'b1)
      tick();
    rd = o_rd_data;
    if (!w)
      chk(n[7:0], 8'(pic_host_pkg::STROBE_CYC));
  endtask
  task automatic ack_run;
    vq = {};
    n = 0;
    while (o_ack_done !== 1'b1)
    begin
      tick();
      if (o_vec_valid === 1'b1)
      begin
        vq.push_back(o_vec_data);
        chk({5'h00, cas}, {5'h00, l});
      end
    end
    chk(8'(vq.size()), i_call_mode ? 8'h02 : 8'h01);
    if (i_call_mode)
    begin
      chk(vq[0], {VBASE[7:5], l, 2'h0});
      chk(vq[1], AHI);
    end
    else
      chk(vq[0], {VBASE[7:3], l});
  endtask
  initial
  begin
    seed = 32'ha194a314;
    repeat (16) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($random(seed));
      cmd(1'b1, 1'b1, d);
      cmd(1'b0, 1'b1, 8'h00);
      chk(rd, d);
    end
    cmd(1'b1, 1'b1, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      l = 3'($random(seed));
      i_call_mode = k[0];
      req[l] = 1'b1;
      ack_run();
      cmd(1'b0, 1'b0, 8'h00);
      chk(rd, 8'h00);
      req[l] = 1'b0;
      cmd(1'b1, 1'b0, 8'h20);
    end
    // Level mode: a pin left high interrupts again after end-of-service
    lvl = 1'b1;
    l = 3'($random(seed));
    req[l] = 1'b1;
    ack_run();
    cmd(1'b1, 1'b0, 8'h20);
    ack_run();
    req[l] = 1'b0;
    cmd(1'b1, 1'b0, 8'h20);
    cmd(1'b0, 1'b0, 8'h00);
    chk(rd, 8'h00);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
